// ### rtl/krtra_pkg.sv
// Shared widths, field positions, reset values and state codes for the training access port.
// Assumes both ends and the interface compile after this package.
package krtra_pkg;

    localparam int ADDR_W        = 21;
    localparam int DEV_FIELD_MSB = 20;
    localparam int DEV_FIELD_LSB = 16;
    localparam int DATA_W        = 16;
    localparam int CFG_ADDR_W    = 16;
    localparam int MGMT_DEPTH    = 16;

    localparam logic [DATA_W-1:0] MGMT_RESET_VALUE = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO        = 16'h0000;
    localparam logic [CFG_ADDR_W-1:0] CFG_ADDR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ACCESS_ADDR_ZERO = 21'h00_0000;
    localparam logic [DEV_FIELD_MSB-DEV_FIELD_LSB:0] DEV_FIELD_ZERO = 5'h00;

    // Device end sequencing, one-hot.
    typedef enum logic [5:0] {
        KRTRA_IDLE     = 6'b00_0001,
        KRTRA_MGMT     = 6'b00_0010,
        KRTRA_REQUEST  = 6'b00_0100,
        KRTRA_STROBE   = 6'b00_1000,
        KRTRA_WAIT_RDY = 6'b01_0000,
        KRTRA_ACK      = 6'b10_0000
    } krtra_state_t;

    // Training side sequencing, one-hot.
    typedef enum logic [3:0] {
        KRTRA_T_IDLE   = 4'b0001,
        KRTRA_T_ISSUE  = 4'b0010,
        KRTRA_T_WAIT   = 4'b0100,
        KRTRA_T_RETURN = 4'b1000
    } krtra_trn_state_t;

endpackage

// ### rtl/krtra_if.sv
// Link between the device end and the training algorithm with its configuration-port arbiter.
// Assumes one clock for both parties; the testbench supplies it and joins the two ends.
`timescale 1ns/1ns
interface krtra_if (
    input wire logic sys_clk
);
    // Training access port.
    logic                               access_trigger;
    logic [krtra_pkg::ADDR_W-1:0]       access_addr;
    logic                               access_read;
    logic [krtra_pkg::DATA_W-1:0]       access_write_value;
    logic                               core_reg_select;
    logic                               xcvr_cfg_select;
    logic [krtra_pkg::DATA_W-1:0]       access_read_value;
    logic                               read_done;
    logic                               write_done;
    // Arbitration.
    logic                               cfg_request;
    logic                               cfg_grant;
    // Core-side configuration bus.
    logic [krtra_pkg::CFG_ADDR_W-1:0]   core_side_cfg_address;
    logic                               core_side_cfg_strobe;
    logic [krtra_pkg::DATA_W-1:0]       core_side_cfg_write_value;
    logic                               core_side_cfg_write_strobe;
    logic [krtra_pkg::DATA_W-1:0]       core_side_cfg_read_value;
    logic                               core_side_cfg_ready;
    // User-side configuration bus.
    logic [krtra_pkg::CFG_ADDR_W-1:0]   user_side_cfg_address;
    logic                               user_side_cfg_strobe;
    logic [krtra_pkg::DATA_W-1:0]       user_side_cfg_write_value;
    logic                               user_side_cfg_write_strobe;
    logic [krtra_pkg::DATA_W-1:0]       user_side_cfg_read_value;
    logic                               user_side_cfg_ready;

    modport device (
        input  access_trigger, access_addr, access_read, access_write_value,
        input  core_reg_select, xcvr_cfg_select,
        output access_read_value, read_done, write_done,
        output cfg_request,
        input  cfg_grant,
        output core_side_cfg_address, core_side_cfg_strobe,
        output core_side_cfg_write_value, core_side_cfg_write_strobe,
        input  core_side_cfg_read_value, core_side_cfg_ready,
        input  user_side_cfg_address, user_side_cfg_strobe,
        input  user_side_cfg_write_value, user_side_cfg_write_strobe,
        output user_side_cfg_read_value, user_side_cfg_ready
    );

    modport trainer (
        output access_trigger, access_addr, access_read, access_write_value,
        output core_reg_select, xcvr_cfg_select,
        input  access_read_value, read_done, write_done,
        input  cfg_request,
        output cfg_grant,
        input  core_side_cfg_address, core_side_cfg_strobe,
        input  core_side_cfg_write_value, core_side_cfg_write_strobe,
        output core_side_cfg_read_value, core_side_cfg_ready,
        output user_side_cfg_address, user_side_cfg_strobe,
        output user_side_cfg_write_value, user_side_cfg_write_strobe,
        input  user_side_cfg_read_value, user_side_cfg_ready
    );
endinterface

// ### rtl/krtra_trainer_end.sv
// Training algorithm end: runs one access per command and acts as a pass-through arbiter.
// Assumes the device end on the other side of krtra_if and a single clock.
`timescale 1ns/1ns
module krtra_trainer_end #(
    parameter bit HAS_MGMT_IF = 1'b1
) (
    // Clock and reset.
    input  wire logic                           sys_clk,
    input  wire logic                           srst,
    // Link to the device.
    krtra_if.trainer                            link,
    // Command port.
    input  wire logic                           cmd_start,
    input  wire logic [krtra_pkg::ADDR_W-1:0]   cmd_addr,
    input  wire logic                           cmd_read,
    input  wire logic                           cmd_target_core,
    input  wire logic [krtra_pkg::DATA_W-1:0]   cmd_write_value,
    output logic                                cmd_busy,
    output logic                                cmd_done,
    output logic [krtra_pkg::DATA_W-1:0]        cmd_read_value
);
    krtra_pkg::krtra_trn_state_t state;
    krtra_pkg::krtra_trn_state_t next_state;

    wire ack_seen   = link.read_done | link.write_done;
    wire start_ok   = cmd_start & state == krtra_pkg::KRTRA_T_IDLE;
    // Without a management interface the core select stays low.
    wire core_sel   = cmd_target_core & HAS_MGMT_IF;

    always_comb begin
        next_state = state;
        case (state)
            krtra_pkg::KRTRA_T_IDLE:   if (cmd_start) next_state = krtra_pkg::KRTRA_T_ISSUE;
            krtra_pkg::KRTRA_T_ISSUE:  next_state = krtra_pkg::KRTRA_T_WAIT;
            krtra_pkg::KRTRA_T_WAIT:   if (ack_seen) next_state = krtra_pkg::KRTRA_T_RETURN;
            krtra_pkg::KRTRA_T_RETURN: next_state = krtra_pkg::KRTRA_T_IDLE;
            default:                   next_state = krtra_pkg::KRTRA_T_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state                   <= krtra_pkg::KRTRA_T_IDLE;
            link.access_trigger     <= 1'b0;
            link.core_reg_select    <= 1'b0;
            link.xcvr_cfg_select    <= 1'b0;
            link.access_addr        <= krtra_pkg::ACCESS_ADDR_ZERO;
            link.access_read        <= 1'b0;
            link.access_write_value <= krtra_pkg::DATA_ZERO;
            cmd_done                <= 1'b0;
            cmd_read_value          <= krtra_pkg::DATA_ZERO;
        end else begin
            state    <= next_state;
            cmd_done <= 1'b0;
            if (start_ok) begin
                link.access_addr        <= cmd_addr;
                link.access_read        <= cmd_read;
                link.access_write_value <= cmd_write_value;
                link.core_reg_select    <= core_sel;
                link.xcvr_cfg_select    <= ~cmd_target_core;
            end
            if (state == krtra_pkg::KRTRA_T_ISSUE) begin
                link.access_trigger <= 1'b1;
            end
            if (state == krtra_pkg::KRTRA_T_WAIT && ack_seen) begin
                // Trigger and both selects drop low before the next access; address, direction and write value stay held.
                link.access_trigger  <= 1'b0;
                link.core_reg_select <= 1'b0;
                link.xcvr_cfg_select <= 1'b0;
                cmd_done             <= 1'b1;
                if (link.read_done) begin
                    cmd_read_value <= link.access_read_value;
                end
            end
        end
    end

    assign cmd_busy = state != krtra_pkg::KRTRA_T_IDLE;

    // Loop-back arbiter: grant follows request, buses pass one stage.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.cfg_grant                  <= 1'b0;
            link.user_side_cfg_address      <= krtra_pkg::CFG_ADDR_ZERO;
            link.user_side_cfg_strobe       <= 1'b0;
            link.user_side_cfg_write_value  <= krtra_pkg::DATA_ZERO;
            link.user_side_cfg_write_strobe <= 1'b0;
            link.core_side_cfg_read_value   <= krtra_pkg::DATA_ZERO;
            link.core_side_cfg_ready        <= 1'b0;
        end else begin
            link.cfg_grant                  <= link.cfg_request;
            link.user_side_cfg_address      <= link.core_side_cfg_address;
            link.user_side_cfg_strobe       <= link.core_side_cfg_strobe;
            link.user_side_cfg_write_value  <= link.core_side_cfg_write_value;
            link.user_side_cfg_write_strobe <= link.core_side_cfg_write_strobe;
            link.core_side_cfg_read_value   <= link.user_side_cfg_read_value;
            link.core_side_cfg_ready        <= link.user_side_cfg_ready;
        end
    end
endmodule

// ### rtl/krtra_device_end.sv
// Device end of the training access port: management register bank and configuration bridge.
// Assumes one clock shared with the training logic and a transceiver port on the same clock.
`timescale 1ns/1ns
module krtra_device_end #(
    parameter bit BACKPLANE_BUILD = 1'b1,
    parameter bit HAS_MGMT_IF     = 1'b1,
    parameter int MGMT_DEPTH      = krtra_pkg::MGMT_DEPTH
) (
    // Clock and reset.
    input  wire logic                               sys_clk,
    input  wire logic                               srst,
    // Link to the training logic and arbiter.
    krtra_if.device                                 link,
    // Transceiver configuration port.
    output logic [krtra_pkg::CFG_ADDR_W-1:0]        xcvr_cfg_address,
    output logic                                    xcvr_cfg_strobe,
    output logic [krtra_pkg::DATA_W-1:0]            xcvr_cfg_write_value,
    output logic                                    xcvr_cfg_write_strobe,
    input  wire logic [krtra_pkg::DATA_W-1:0]       xcvr_cfg_read_value,
    input  wire logic                               xcvr_cfg_ready,
    // Management register space seen by the rest of the core.
    output logic [krtra_pkg::DATA_W*MGMT_DEPTH-1:0] mgmt_contents,
    output logic [4:0]                              last_device_address_field
);
    localparam int IDX_W = $clog2(MGMT_DEPTH);

    // Reads index the bank directly, so every index value must name a word.
    if (MGMT_DEPTH < 2 || MGMT_DEPTH > 65536
        || (MGMT_DEPTH & (MGMT_DEPTH - 1)) != 0) begin : g_depth_check
        $error("MGMT_DEPTH must be a power of two from 2 to 65536");
    end

    krtra_pkg::krtra_state_t state;
    krtra_pkg::krtra_state_t next_state;

    logic                                trigger_prev;
    logic                                is_read;
    logic [krtra_pkg::ADDR_W-1:0]        addr_held;
    logic [krtra_pkg::DATA_W-1:0]        wdata_held;
    logic [krtra_pkg::DATA_W-1:0]        mgmt_mem [MGMT_DEPTH];

    // The detector starts low, so a trigger already high at release counts as a rise.
    // A level held high never starts a second access.
    wire trigger_rise = link.access_trigger & ~trigger_prev;
    // Without a management interface the core select is ignored.
    wire core_hit     = link.core_reg_select & HAS_MGMT_IF;
    // Transceiver routing yields to the core select only when the management interface is built.
    wire xcvr_hit     = link.xcvr_cfg_select & ~core_hit;
    wire start        = BACKPLANE_BUILD & trigger_rise & (core_hit | xcvr_hit);
    wire [IDX_W-1:0] mgmt_index = addr_held[IDX_W-1:0];
    // A ready that comes with no access pending is ignored by the sequencer.
    wire cfg_done     = link.core_side_cfg_ready;

    always_comb begin
        next_state = state;
        case (state)
            krtra_pkg::KRTRA_IDLE: begin
                if (start && core_hit) begin
                    next_state = krtra_pkg::KRTRA_MGMT;
                end else if (start) begin
                    next_state = krtra_pkg::KRTRA_REQUEST;
                end
            end
            krtra_pkg::KRTRA_MGMT:     next_state = krtra_pkg::KRTRA_ACK;
            krtra_pkg::KRTRA_REQUEST: begin
                if (link.cfg_grant) begin
                    next_state = krtra_pkg::KRTRA_STROBE;
                end
            end
            krtra_pkg::KRTRA_STROBE:   next_state = krtra_pkg::KRTRA_WAIT_RDY;
            krtra_pkg::KRTRA_WAIT_RDY: begin
                if (cfg_done) begin
                    next_state = krtra_pkg::KRTRA_ACK;
                end
            end
            krtra_pkg::KRTRA_ACK:      next_state = krtra_pkg::KRTRA_IDLE;
            default:                   next_state = krtra_pkg::KRTRA_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state                     <= krtra_pkg::KRTRA_IDLE;
            trigger_prev              <= 1'b0;
            is_read                   <= 1'b0;
            addr_held                 <= krtra_pkg::ACCESS_ADDR_ZERO;
            wdata_held                <= krtra_pkg::DATA_ZERO;
            last_device_address_field <= krtra_pkg::DEV_FIELD_ZERO;
        end else begin
            state        <= next_state;
            trigger_prev <= link.access_trigger;
            if (state == krtra_pkg::KRTRA_IDLE && start) begin
                is_read    <= link.access_read;
                addr_held  <= link.access_addr;
                wdata_held <= link.access_write_value;
                last_device_address_field <=
                    link.access_addr[krtra_pkg::DEV_FIELD_MSB:krtra_pkg::DEV_FIELD_LSB];
            end
        end
    end

    // Management register bank; a write lands two cycles after the trigger edge, at the end of KRTRA_MGMT.
    // Only the low address bits pick a word; the device field is recorded, not decoded.
    genvar gi;
    generate
        for (gi = 0; gi < MGMT_DEPTH; gi++) begin : g_mgmt
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    mgmt_mem[gi] <= krtra_pkg::MGMT_RESET_VALUE;
                end else if (state == krtra_pkg::KRTRA_MGMT && !is_read
                             && mgmt_index == IDX_W'(gi)) begin
                    mgmt_mem[gi] <= wdata_held;
                end
            end
            assign mgmt_contents[gi*krtra_pkg::DATA_W +: krtra_pkg::DATA_W] = mgmt_mem[gi];
        end
    endgenerate

    // Answer to the training logic: value held, acknowledges pulse once.
    // The held value changes only when a read completes, never on a write.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.access_read_value <= krtra_pkg::DATA_ZERO;
            link.read_done         <= 1'b0;
            link.write_done        <= 1'b0;
        end else begin
            link.read_done  <= 1'b0;
            link.write_done <= 1'b0;
            if (state == krtra_pkg::KRTRA_MGMT && is_read) begin
                link.access_read_value <= mgmt_mem[mgmt_index];
            end
            if (state == krtra_pkg::KRTRA_WAIT_RDY && cfg_done && is_read) begin
                link.access_read_value <= link.core_side_cfg_read_value;
            end
            if (state == krtra_pkg::KRTRA_ACK) begin
                link.read_done  <= is_read;
                link.write_done <= ~is_read;
            end
        end
    end

    // Core-side configuration bus toward the arbiter.
    // Strobes launch from next_state so they leave in the cycle after grant is seen.
    wire strobe_now = next_state == krtra_pkg::KRTRA_STROBE;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.cfg_request                <= 1'b0;
            link.core_side_cfg_address      <= krtra_pkg::CFG_ADDR_ZERO;
            link.core_side_cfg_strobe       <= 1'b0;
            link.core_side_cfg_write_value  <= krtra_pkg::DATA_ZERO;
            link.core_side_cfg_write_strobe <= 1'b0;
        end else begin
            // Request stays up from the trigger until the ready returns.
            link.cfg_request <= next_state == krtra_pkg::KRTRA_REQUEST
                              || next_state == krtra_pkg::KRTRA_STROBE
                              || next_state == krtra_pkg::KRTRA_WAIT_RDY;
            link.core_side_cfg_strobe       <= strobe_now;
            link.core_side_cfg_write_strobe <= strobe_now & ~is_read;
            if (strobe_now) begin
                link.core_side_cfg_address     <= addr_held[krtra_pkg::CFG_ADDR_W-1:0];
                link.core_side_cfg_write_value <= wdata_held;
            end
        end
    end

    // User-side bus is re-timed once in each direction on its way through.
    // This costs two cycles per access but keeps every transceiver pin on a flop.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            xcvr_cfg_address              <= krtra_pkg::CFG_ADDR_ZERO;
            xcvr_cfg_strobe               <= 1'b0;
            xcvr_cfg_write_value          <= krtra_pkg::DATA_ZERO;
            xcvr_cfg_write_strobe         <= 1'b0;
            link.user_side_cfg_read_value <= krtra_pkg::DATA_ZERO;
            link.user_side_cfg_ready      <= 1'b0;
        end else begin
            xcvr_cfg_address              <= link.user_side_cfg_address;
            xcvr_cfg_strobe               <= link.user_side_cfg_strobe;
            xcvr_cfg_write_value          <= link.user_side_cfg_write_value;
            xcvr_cfg_write_strobe         <= link.user_side_cfg_write_strobe;
            link.user_side_cfg_read_value <= xcvr_cfg_read_value;
            link.user_side_cfg_ready      <= xcvr_cfg_ready;
        end
    end
endmodule

// ### dv/krtra_sva.sv
// Checker for the link between the device end and the training end.
// Assumes it sits beside the krtra_if instance it watches, on that link's clock.
`timescale 1ns/1ns
module krtra_sva (
    // Clock and reset.
    input wire logic                           sys_clk,
    input wire logic                           srst,
    // Training port.
    input wire logic                           access_trigger,
    input wire logic                           access_read,
    input wire logic                           core_reg_select,
    input wire logic                           xcvr_cfg_select,
    input wire logic [krtra_pkg::DATA_W-1:0]   access_read_value,
    input wire logic                           read_done,
    input wire logic                           write_done,
    // Arbitration and configuration buses.
    input wire logic                           cfg_request,
    input wire logic                           cfg_grant,
    input wire logic                           core_side_cfg_strobe,
    input wire logic                           core_side_cfg_ready,
    input wire logic                           user_side_cfg_strobe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_rd_pulse; read_done |=> !read_done; endproperty
    property p_wr_pulse; write_done |=> !write_done; endproperty
    property p_mgmt_rd; $rose(access_trigger) && core_reg_select && access_read |-> ##3 read_done;
    endproperty
    property p_mgmt_wr; $rose(access_trigger) && core_reg_select && !access_read |-> ##3 write_done;
    endproperty
    property p_xcvr_req; $rose(access_trigger) && xcvr_cfg_select && !core_reg_select
        |-> ##1 cfg_request; endproperty
    property p_req_hold; cfg_request && !core_side_cfg_ready |=> cfg_request; endproperty
    property p_strobe_grant; core_side_cfg_strobe |-> cfg_grant && cfg_request; endproperty
    property p_loop_strobe; user_side_cfg_strobe == $past(core_side_cfg_strobe); endproperty
    property p_cfg_done; core_side_cfg_ready |-> ##2 (read_done || write_done); endproperty
    property p_rdata_ack; $changed(access_read_value) |-> ##1 read_done; endproperty

    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read done longer than one cycle");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write done longer than one cycle");
    a_mgmt_rd: assert property (p_mgmt_rd)
        else $error("register read not acknowledged");
    a_mgmt_wr: assert property (p_mgmt_wr)
        else $error("register write not acknowledged");
    a_xcvr_req: assert property (p_xcvr_req)
        else $error("no port request for access");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before ready");
    a_strobe_grant: assert property (p_strobe_grant)
        else $error("strobe without grant");
    a_loop_strobe: assert property (p_loop_strobe)
        else $error("loopback strobe mismatch");
    a_cfg_done: assert property (p_cfg_done)
        else $error("port ready not acknowledged");
    a_rdata_ack: assert property (p_rdata_ack)
        else $error("read value moved without ack");

    c_mgmt_rd: cover property ($rose(access_trigger) && core_reg_select && access_read);
    c_xcvr_wr: cover property (core_side_cfg_strobe ##[1:16] write_done);
    c_xcvr_rd: cover property (core_side_cfg_ready ##2 read_done);
endmodule

// ### dv/testbench.sv
// Self-checking bench: trainer end and device end joined by krtra_if, plus a transceiver stub.
// Assumes the package and the design files are compiled first.
`timescale 1ns/1ns
module testbench;
    logic                           sys_clk = 1'b0;
    logic                           srst = 1'b1;
    logic                           cmd_start = 1'b0;
    logic [krtra_pkg::ADDR_W-1:0]   cmd_addr = 21'h00_0000;
    logic                           cmd_read = 1'b0;
    logic                           cmd_target_core = 1'b0;
    logic [krtra_pkg::DATA_W-1:0]   cmd_write_value = 16'h0000;
    logic                           cmd_busy;
    logic                           cmd_done;
    logic [krtra_pkg::DATA_W-1:0]   cmd_read_value;
    logic [15:0]                    xcvr_cfg_address;
    logic                           xcvr_cfg_strobe;
    logic [15:0]                    xcvr_cfg_write_value;
    logic                           xcvr_cfg_write_strobe;
    logic [15:0]                    xcvr_cfg_read_value = 16'h0000;
    logic                           xcvr_cfg_ready = 1'b0;
    logic [16*krtra_pkg::MGMT_DEPTH-1:0] mgmt_contents;
    logic [4:0]                     last_field;
    logic [15:0]                    xmem [16];
    logic [15:0]                    xaddr_seen = 16'h0000;
    logic [2:0]                     xpend = 3'h0;
    int                             bad_count = 0;
    int                             num_checks = 0;
    int                             rd_pulses = 0;
    int                             wr_pulses = 0;
    int                             exp_rd = 0;
    int                             exp_wr = 0;

    always #2 sys_clk = ~sys_clk;

    krtra_if link_if (.sys_clk(sys_clk));
    krtra_trainer_end krtra_trainer_end_inst (.sys_clk(sys_clk), .srst(srst), .link(link_if),
        .cmd_start(cmd_start), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
        .cmd_target_core(cmd_target_core), .cmd_write_value(cmd_write_value),
        .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_read_value(cmd_read_value));
    krtra_device_end krtra_device_end_inst (.sys_clk(sys_clk), .srst(srst), .link(link_if),
        .xcvr_cfg_address(xcvr_cfg_address), .xcvr_cfg_strobe(xcvr_cfg_strobe),
        .xcvr_cfg_write_value(xcvr_cfg_write_value), .xcvr_cfg_write_strobe(xcvr_cfg_write_strobe),
        .xcvr_cfg_read_value(xcvr_cfg_read_value), .xcvr_cfg_ready(xcvr_cfg_ready),
        .mgmt_contents(mgmt_contents), .last_device_address_field(last_field));
    krtra_sva krtra_sva_inst (.sys_clk(sys_clk), .srst(srst),
        .access_trigger(link_if.access_trigger), .access_read(link_if.access_read),
        .core_reg_select(link_if.core_reg_select), .xcvr_cfg_select(link_if.xcvr_cfg_select),
        .access_read_value(link_if.access_read_value), .read_done(link_if.read_done),
        .write_done(link_if.write_done), .cfg_request(link_if.cfg_request),
        .cfg_grant(link_if.cfg_grant), .core_side_cfg_strobe(link_if.core_side_cfg_strobe),
        .core_side_cfg_ready(link_if.core_side_cfg_ready),
        .user_side_cfg_strobe(link_if.user_side_cfg_strobe));

    // Transceiver stub answers four cycles after a strobe; between answers the read value
    // toggles so a design that samples it at the wrong moment sees garbage, not old data.
    always @(posedge sys_clk) begin
        xcvr_cfg_ready <= (xpend == 3'h1);
        xcvr_cfg_read_value <= (xpend == 3'h1) ? xmem[xaddr_seen[3:0]] : ~xcvr_cfg_read_value;
        if (xpend != 3'h0) xpend <= xpend - 3'h1;
        if (xcvr_cfg_strobe === 1'b1) begin
            xpend <= 3'h4;
            xaddr_seen <= xcvr_cfg_address;
            if (xcvr_cfg_write_strobe === 1'b1) begin
                xmem[xcvr_cfg_address[3:0]] <= xcvr_cfg_write_value;
            end
        end
        if (link_if.read_done === 1'b1) rd_pulses++;
        if (link_if.write_done === 1'b1) wr_pulses++;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic run_cmd(input logic [20:0] addr, input logic rd, input logic core,
                           input logic [15:0] wv);
        int n;
        n = 0;
        while (cmd_busy !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cmd_addr = addr;
        cmd_read = rd;
        cmd_target_core = core;
        cmd_write_value = wv;
        cmd_start = 1'b1;
        if (rd) exp_rd++; else exp_wr++;
        @(posedge sys_clk);
        #1;
        cmd_start = 1'b0;
        while (cmd_done !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 200) check("command completion", 16'h0001, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_mgmt_path;
        run_cmd(21'h1e_0005, 1'b0, 1'b1, 16'ha5c3);
        check("mgmt word 5", 16'ha5c3, mgmt_contents[16*5+:16]);
        check("device field", 16'h001e, {11'h000, last_field});
        run_cmd(21'h03_000f, 1'b0, 1'b1, 16'h0f0f);
        run_cmd(21'h1e_0005, 1'b1, 1'b1, 16'h0000);
        check("mgmt read 5", 16'ha5c3, cmd_read_value);
        run_cmd(21'h03_0000, 1'b1, 1'b1, 16'h0000);
        check("mgmt read 0 reset", krtra_pkg::MGMT_RESET_VALUE, cmd_read_value);
        check("mgmt word 15", 16'h0f0f, mgmt_contents[16*15+:16]);
    endtask

    task automatic t_xcvr_path;
        run_cmd(21'h01_0007, 1'b0, 1'b0, 16'h3c5a);
        check("xcvr write data", 16'h3c5a, xmem[7]);
        check("xcvr address", 16'h0007, xaddr_seen);
        run_cmd(21'h01_0007, 1'b1, 1'b0, 16'hffff);
        check("xcvr read", 16'h3c5a, cmd_read_value);
        check("device field", 16'h0001, {11'h000, last_field});
    endtask

    // Alternating register spaces back to back catches state left over from the other path.
    task automatic t_back_to_back;
        for (int i = 0; i < 4; i++) begin
            run_cmd({5'h02, 12'h000, i[3:0]}, 1'b0, 1'b1, 16'h1000 + 16'(i));
            run_cmd({5'h01, 12'h000, i[3:0]}, 1'b0, 1'b0, 16'h2000 + 16'(i));
            run_cmd({5'h02, 12'h000, i[3:0]}, 1'b1, 1'b1, 16'h0000);
            check("mgmt back to back", 16'h1000 + 16'(i), cmd_read_value);
            run_cmd({5'h01, 12'h000, i[3:0]}, 1'b1, 1'b0, 16'h0000);
            check("xcvr back to back", 16'h2000 + 16'(i), cmd_read_value);
        end
        check("read ack count", 16'(exp_rd), 16'(rd_pulses));
        check("write ack count", 16'(exp_wr), 16'(wr_pulses));
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        $display("BAD watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        t_mgmt_path();
        t_xcvr_path();
        t_back_to_back();
        wrap_up();
    end
endmodule
